// ### trim_pkg.sv
// Package of constants, register map and types for the trim control block
package trim_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_CHANNELS = 4;
    localparam int OFFSET_W     = 8;
    localparam int GAIN_W       = 6;
    localparam int RANGE_W      = 2;
    localparam int DATA_W       = 16;
    localparam int IO_W         = 2;

    // ------------------------------------------------------------------
    // Register byte offsets (APB, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_FUNC   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IO     = 8'h08;
    localparam logic [7:0] ADDR_CH0    = 8'h10;

    // Per channel: data, range, gain, offset words
    localparam logic [7:0] CH_STRIDE   = 8'h10;
    localparam logic [3:0] SUB_DATA    = 4'h0;
    localparam logic [3:0] SUB_RANGE   = 4'h4;
    localparam logic [3:0] SUB_GAIN    = 4'h8;
    localparam logic [3:0] SUB_OFFSET  = 4'hC;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int FUNC_LGND_BIT  = 0;
    localparam int FUNC_IODIR_BIT = 1;
    localparam int STAT_CLAMP_BIT = 0;
    localparam int STAT_SUPOK_BIT = 1;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [OFFSET_W-1:0] OFFSET_RESET = 8'h00;
    localparam logic [GAIN_W-1:0]   GAIN_RESET   = 6'h00;
    localparam logic [RANGE_W-1:0]  RANGE_10V00  = 2'h0;
    localparam logic [RANGE_W-1:0]  RANGE_10V26  = 2'h1;
    localparam logic [RANGE_W-1:0]  RANGE_10V53  = 2'h2;
    localparam logic [DATA_W-1:0]   CODE_ZERO    = 16'h0000;
    localparam logic [DATA_W-1:0]   CODE_NEG_FS  = 16'h8000;
    localparam logic [1:0]          SYNC_RESET   = 2'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0]   data;
        logic [RANGE_W-1:0]  range_sel;
        logic [GAIN_W-1:0]   gain_trim;
        logic [OFFSET_W-1:0] offset_trim;
    } chan_cfg_t;

    typedef struct packed {
        logic amp_path_gate;
        logic clamp_gate;
    } gate_t;

    typedef enum logic [0:0] {
        CLAMPED,
        RELEASED
    } clamp_state_t;

endpackage

// ### bit_sync.sv
// Two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module bit_sync
    import trim_pkg::*;
(
    input  wire logic MCLK,
    input  wire logic RESET,
    input  wire logic CE,
    input  wire logic D,
    output logic      Q
);

    typedef struct packed {
        logic [1:0] pipe;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    // Shift the level through two flops
    always_comb begin
        next_state = state;
        if (CE) begin
            next_state.pipe = {state.pipe[0], D};
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            state <= '{pipe: SYNC_RESET};
        end else begin
            state <= next_state;
        end
    end

    assign Q = state.pipe[1];

endmodule

// ### output_clamp.sv
// Output clamp controller: holds the outputs at ground until released
`timescale 1ns/1ps
module output_clamp
    import trim_pkg::*;
(
    input  wire logic MCLK,
    input  wire logic RESET,
    input  wire logic CE,
    input  wire logic supply_ok,
    input  wire logic reset_input_n,
    input  wire logic data_written,
    output gate_t     gates,
    output logic      clamped
);

    typedef struct packed {
        clamp_state_t fsm;
        gate_t        gates;
    } clamp_reg_t;

    clamp_reg_t state;
    clamp_reg_t next_state;

    // Release needs stable supplies and a data write; reset pin re-clamps
    always_comb begin
        next_state = state;
        if (CE) begin
            case (state.fsm)
                CLAMPED: begin
                    if (supply_ok && reset_input_n && data_written) begin
                        next_state.fsm = RELEASED;
                    end
                end
                RELEASED: begin
                    if (!supply_ok || !reset_input_n) begin
                        next_state.fsm = CLAMPED;
                    end
                end
                default: next_state.fsm = CLAMPED;
            endcase
            // Gates follow the next state
            next_state.gates.clamp_gate    =
                (next_state.fsm == CLAMPED);
            next_state.gates.amp_path_gate =
                (next_state.fsm == RELEASED);
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            state <= '{fsm: CLAMPED,
                       gates: '{amp_path_gate: 1'b0, clamp_gate: 1'b1}};
        end else begin
            state <= next_state;
        end
    end

    assign gates   = state.gates;
    assign clamped = (state.fsm == CLAMPED);

    // Gates never on together, and mirror the state
    AST_GATES_EXCLUSIVE: assert property (@(posedge MCLK) disable iff (RESET)
        gates.clamp_gate != gates.amp_path_gate)
        else $error("clamp and amp gates not exclusive");

    AST_RESET_PIN_CLAMPS: assert property (@(posedge MCLK) disable iff (RESET)
        (CE && !reset_input_n) |=> gates.clamp_gate)
        else $error("reset input did not clamp output");

    AST_NO_RELEASE_NO_WRITE: assert property (@(posedge MCLK)
        disable iff (RESET)
        (clamped && !(CE && data_written)) |=> clamped)
        else $error("clamp released without data write");

endmodule

// ### dac_output_trim_control.sv
// Per-channel trim, range, clamp and I/O control with APB register access
//
// Summary of operation
// - Eight bit signed offset trim per channel
// - Offset steps of one eighth LSB
// - Six bit signed fine gain trim
// - Three selectable bipolar output spans
// - Clamp outputs until supplies good and write
// - Release opens clamp and connects amplifier
// - Low reset input clamps and disconnects amplifier
// - Supply detector result drives an output pin
// - Two I/O pins, input or output
// - Host sets output levels, reads pin levels
// - Local ground compensation only when enabled
// - Code 0x0000 gives nominal zero output
// - Code 0x8000 gives negative full scale
// - Range code 00/01/10 selects span
// - Gain trim spans minus 32 to 31
// - Direction bit one makes both pins outputs
// - Values drive outputs; reads report pin levels
`timescale 1ns/1ps
module dac_output_trim_control
    import trim_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
)
(
    input  wire logic                       MCLK,
    input  wire logic                       RESET,
    input  wire logic                       CE,
    // APB slave
    input  wire logic                       PSEL,
    input  wire logic                       PENABLE,
    input  wire logic                       PWRITE,
    input  wire logic [7:0]                 PADDR,
    input  wire logic [31:0]                PWDATA,
    output logic      [31:0]                PRDATA,
    output logic                            PREADY,
    output logic                            PSLVERR,
    // Pins
    input  wire logic                       RESET_INPUT_N,
    input  wire logic                       SUPPLY_OK,
    output logic                            SUPPLY_MONITOR_OUT,
    input  wire logic                       IO_PIN_ZERO_IN,
    output logic                            IO_PIN_ZERO_OUT,
    output logic                            IO_PIN_ZERO_OE,
    input  wire logic                       IO_PIN_ONE_IN,
    output logic                            IO_PIN_ONE_OUT,
    output logic                            IO_PIN_ONE_OE,
    // Analog control
    output logic                            AMP_PATH_GATE,
    output logic                            CLAMP_GATE,
    output logic                            LOCAL_GROUND_ADJ_EN,
    output logic [CHANNELS*DATA_W-1:0]      CHANNEL_CODE,
    output logic [CHANNELS*RANGE_W-1:0]     RANGE_SEL,
    output logic [CHANNELS*GAIN_W-1:0]      GAIN_TRIM,
    output logic [CHANNELS*OFFSET_W-1:0]    OFFSET_TRIM
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        chan_cfg_t [CHANNELS-1:0] chan;
        logic                     lgnd_en;
        logic                     io_dir;
        logic [IO_W-1:0]          io_value;
        logic [31:0]              rdata;
        logic                     slverr;
        logic                     data_written;
        logic                     ack;
    } top_state_t;

    top_state_t state;
    top_state_t next_state;

    logic            supply_ok_s;
    logic            reset_in_s;
    logic [IO_W-1:0] io_in_s;
    gate_t           gates;
    logic            clamped;

    // ------------------------------------------------------------------
    // Synchronisers for pin inputs
    // ------------------------------------------------------------------
    bit_sync u_sync_sup (
        .MCLK  (MCLK),
        .RESET (RESET),
        .CE    (CE),
        .D     (SUPPLY_OK),
        .Q     (supply_ok_s)
    );

    bit_sync u_sync_rst (
        .MCLK  (MCLK),
        .RESET (RESET),
        .CE    (CE),
        .D     (RESET_INPUT_N),
        .Q     (reset_in_s)
    );

    bit_sync u_sync_io0 (
        .MCLK  (MCLK),
        .RESET (RESET),
        .CE    (CE),
        .D     (IO_PIN_ZERO_IN),
        .Q     (io_in_s[0])
    );

    bit_sync u_sync_io1 (
        .MCLK  (MCLK),
        .RESET (RESET),
        .CE    (CE),
        .D     (IO_PIN_ONE_IN),
        .Q     (io_in_s[1])
    );

    // ------------------------------------------------------------------
    // Output clamp controller
    // ------------------------------------------------------------------
    output_clamp u_clamp (
        .MCLK          (MCLK),
        .RESET         (RESET),
        .CE            (CE),
        .supply_ok     (supply_ok_s),
        .reset_input_n (reset_in_s),
        .data_written  (state.data_written),
        .gates         (gates),
        .clamped       (clamped)
    );

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic       access;
    logic       in_chan;
    logic [1:0] ch_idx;
    logic [3:0] sub;

    assign access  = PSEL && PENABLE && CE;
    assign in_chan = (PADDR >= ADDR_CH0) &&
                     (PADDR < (ADDR_CH0 + 8'(CHANNELS) * CH_STRIDE));
    assign ch_idx  = 2'((PADDR - ADDR_CH0) >> 4);
    assign sub     = PADDR[3:0];

    // A transfer is taken in its second access cycle, once ready is up
    logic       take;
    logic       wr_en;
    assign take    = access && state.ack;
    assign wr_en   = take && PWRITE;

    // Register writes, reads and the data-write pulse
    always_comb begin
        next_state = state;
        if (CE) begin
            next_state.data_written = 1'b0;
            next_state.slverr       = 1'b0;
            next_state.rdata        = 32'h0000_0000;
            next_state.ack          = access && !state.ack;
        end
        if (access) begin
            if (PADDR == ADDR_FUNC) begin
                if (wr_en) begin
                    next_state.lgnd_en = PWDATA[FUNC_LGND_BIT];
                    next_state.io_dir  = PWDATA[FUNC_IODIR_BIT];
                end
                next_state.rdata[FUNC_LGND_BIT]  = state.lgnd_en;
                next_state.rdata[FUNC_IODIR_BIT] = state.io_dir;
            end else if (PADDR == ADDR_STATUS) begin
                next_state.rdata[STAT_CLAMP_BIT] = clamped;
                next_state.rdata[STAT_SUPOK_BIT] = supply_ok_s;
            end else if (PADDR == ADDR_IO) begin
                if (wr_en && state.io_dir) begin
                    next_state.io_value = PWDATA[IO_W-1:0];
                end
                next_state.rdata[IO_W-1:0] = io_in_s;
            end else if (in_chan && sub == SUB_DATA) begin
                if (wr_en) begin
                    next_state.chan[ch_idx].data = PWDATA[DATA_W-1:0];
                    next_state.data_written      = 1'b1;
                end
                next_state.rdata[DATA_W-1:0] = state.chan[ch_idx].data;
            end else if (in_chan && sub == SUB_RANGE) begin
                if (wr_en && PWDATA[RANGE_W-1:0] != 2'h3) begin
                    next_state.chan[ch_idx].range_sel =
                        PWDATA[RANGE_W-1:0];
                end
                next_state.rdata[RANGE_W-1:0] =
                    state.chan[ch_idx].range_sel;
            end else if (in_chan && sub == SUB_GAIN) begin
                if (wr_en) begin
                    next_state.chan[ch_idx].gain_trim =
                        PWDATA[GAIN_W-1:0];
                end
                next_state.rdata[GAIN_W-1:0] =
                    state.chan[ch_idx].gain_trim;
            end else if (in_chan && sub == SUB_OFFSET) begin
                if (wr_en) begin
                    next_state.chan[ch_idx].offset_trim =
                        PWDATA[OFFSET_W-1:0];
                end
                next_state.rdata[OFFSET_W-1:0] =
                    state.chan[ch_idx].offset_trim;
            end else begin
                next_state.slverr = 1'b1;
            end
        end
    end

    // Register the state; per-channel defaults on reset
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            state <= '0;
            for (int i = 0; i < CHANNELS; i++) begin
                state.chan[i] <= '{data: CODE_ZERO,
                                   range_sel: RANGE_10V00,
                                   gain_trim: GAIN_RESET,
                                   offset_trim: OFFSET_RESET};
            end
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // APB answers after one wait state; read data and error from flops
    assign PREADY  = state.ack;
    assign PRDATA  = state.rdata;
    assign PSLVERR = state.ack && state.slverr;

    // Supply detector result straight to its pin (synchronised)
    assign SUPPLY_MONITOR_OUT  = supply_ok_s;
    assign AMP_PATH_GATE       = gates.amp_path_gate;
    assign CLAMP_GATE          = gates.clamp_gate;
    assign LOCAL_GROUND_ADJ_EN = state.lgnd_en;

    // Both pins share one direction bit
    assign IO_PIN_ZERO_OE  = state.io_dir;
    assign IO_PIN_ONE_OE   = state.io_dir;
    assign IO_PIN_ZERO_OUT = state.io_value[0];
    assign IO_PIN_ONE_OUT  = state.io_value[1];

    // Per-channel fields flattened; code forced to zero while clamped.
    // Offset LSB is 1/8 code LSB, gain trim -32..31, code 0x0000 is zero,
    // 0x8000 negative full scale in twos complement.
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_chan
            assign CHANNEL_CODE[g*DATA_W +: DATA_W] =
                clamped ? CODE_ZERO : state.chan[g].data;
            assign RANGE_SEL[g*RANGE_W +: RANGE_W] =
                state.chan[g].range_sel;
            assign GAIN_TRIM[g*GAIN_W +: GAIN_W] =
                state.chan[g].gain_trim;
            assign OFFSET_TRIM[g*OFFSET_W +: OFFSET_W] =
                state.chan[g].offset_trim;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_offset_write;
        wr_en && in_chan && sub == SUB_OFFSET;
    endsequence

    AST_OFFSET_STORED: assert property (@(posedge MCLK) disable iff (RESET)
        s_offset_write |=> OFFSET_TRIM[$past(ch_idx)*OFFSET_W +: OFFSET_W]
            == $past(PWDATA[OFFSET_W-1:0]))
        else $error("offset trim not stored");

    AST_GAIN_STORED: assert property (@(posedge MCLK) disable iff (RESET)
        (wr_en && in_chan && sub == SUB_GAIN) |=>
        GAIN_TRIM[$past(ch_idx)*GAIN_W +: GAIN_W]
            == $past(PWDATA[GAIN_W-1:0]))
        else $error("gain trim not stored");

    AST_RANGE_LEGAL: assert property (@(posedge MCLK) disable iff (RESET)
        state.chan[0].range_sel != 2'h3)
        else $error("illegal range code held");

    AST_IO_OE: assert property (@(posedge MCLK) disable iff (RESET)
        IO_PIN_ZERO_OE == IO_PIN_ONE_OE)
        else $error("io pins differ in direction");

    AST_IO_IGNORED: assert property (@(posedge MCLK) disable iff (RESET)
        (!state.io_dir && CE) |=> $stable(state.io_value))
        else $error("io value written while input");

    AST_CLAMP_ZERO: assert property (@(posedge MCLK) disable iff (RESET)
        CLAMP_GATE |-> CHANNEL_CODE == '0)
        else $error("code not zero while clamped");

    AST_SUPPLY_MON: assert property (@(posedge MCLK) disable iff (RESET)
        CE ##1 CE ##1 CE |-> SUPPLY_MONITOR_OUT == $past(SUPPLY_OK, 2))
        else $error("supply monitor does not follow detector");

    AST_LGND_EN: assert property (@(posedge MCLK) disable iff (RESET)
        (wr_en && PADDR == ADDR_FUNC) |=>
        LOCAL_GROUND_ADJ_EN == $past(PWDATA[FUNC_LGND_BIT]))
        else $error("ground adjust enable not stored");

endmodule

// ### host_model.sv
// Host bus master model issuing APB register transfers
`timescale 1ns/1ps
module host_model (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // Idle bus from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // One transfer: setup, access held until ready, then release
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q        = prdata;
        err      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ### dac_output_trim_control_test.sv
// Self-checking testbench for the trim control block
`timescale 1ns/1ps
module dac_output_trim_control_test import trim_pkg::*;;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        ce = 1'b1;
    logic        rst_in_n = 1'b1;
    logic        supply_ok = 1'b0;
    logic        ext0 = 1'b0;
    logic        ext1 = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        mon, out0, oe0, out1, oe1, amp, clamp, lgnd;
    logic [63:0] code;
    logic [7:0]  rng;
    logic [23:0] gain;
    logic [31:0] offs;
    wire         pin0 = oe0 ? out0 : ext0;
    wire         pin1 = oe1 ? out1 : ext1;
    int          bad_count = 0;
    int          n_checks = 0;

    // --------------------------------------------------------------
    // Clock, reset, instances
    // --------------------------------------------------------------
    always #10 mclk = ~mclk;

    host_model host_u (.clk(mclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    dac_output_trim_control dut_u (.MCLK(mclk), .RESET(reset), .CE(ce),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .RESET_INPUT_N(rst_in_n),
        .SUPPLY_OK(supply_ok), .SUPPLY_MONITOR_OUT(mon),
        .IO_PIN_ZERO_IN(pin0), .IO_PIN_ZERO_OUT(out0),
        .IO_PIN_ZERO_OE(oe0), .IO_PIN_ONE_IN(pin1),
        .IO_PIN_ONE_OUT(out1), .IO_PIN_ONE_OE(oe1),
        .AMP_PATH_GATE(amp), .CLAMP_GATE(clamp),
        .LOCAL_GROUND_ADJ_EN(lgnd), .CHANNEL_CODE(code),
        .RANGE_SEL(rng), .GAIN_TRIM(gain), .OFFSET_TRIM(offs));

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic [7:0] ca(input int ch, input logic [3:0] s);
        return ADDR_CH0 + CH_STRIDE * ch[7:0] + {4'h0, s};
    endfunction

    task automatic chk(input logic [63:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        host_u.xfer(1'b1, a, d, q, e);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        host_u.xfer(1'b0, a, 32'h0000_0000, q, e);
        #1;
    endtask

    // Bounded wait for the amplifier gate to reach a level
    task automatic wait_gate(input logic want);
        for (int i = 0; i < 12 && amp !== want; i++) begin
            @(posedge mclk);
            #1;
        end
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_reset();
        chk({amp, clamp, oe0, oe1, mon}, 5'h08, "reset gates");
        chk({rng, gain, offs}, 64'h0, "reset trims");
        chk(code, 64'h0, "reset codes");
        $display("test reset done");
    endtask

    task automatic t_trims();
        logic [31:0] q;
        wr(ca(0, SUB_OFFSET), 32'h0000_007F);
        wr(ca(2, SUB_OFFSET), 32'h0000_00F0);
        wr(ca(3, SUB_OFFSET), 32'h0000_0080);
        chk(offs, 64'h80F0_007F, "offset");
        rd(ca(2, SUB_OFFSET), q);
        chk(q, 64'hF0, "offset readback");
        wr(ca(1, SUB_GAIN), 32'h0000_0008);
        wr(ca(0, SUB_GAIN), 32'h0000_0020);
        wr(ca(3, SUB_GAIN), 32'h0000_001F);
        chk(gain, {6'h1F, 6'h00, 6'h08, 6'h20}, "gain");
        for (int r = 0; r < 3; r++) begin
            wr(ca(3, SUB_RANGE), r);
            chk(rng, {r[1:0], 6'h00}, "range");
        end
        wr(ca(3, SUB_RANGE), 32'h0000_0003);
        chk(rng, {RANGE_10V53, 6'h00}, "reserved range");
        $display("test trims done");
    endtask

    task automatic t_clamp();
        logic [31:0] q;
        wr(ca(0, SUB_DATA), 32'h0000_1234);
        repeat (6) @(posedge mclk);
        #1;
        chk({amp, clamp, mon}, 3'h2, "clamp low supply");
        chk(code, 64'h0, "code forced");
        supply_ok <= 1'b1;
        repeat (6) @(posedge mclk);
        #1;
        chk({amp, clamp, mon}, 3'h3, "no write yet");
        rd(ADDR_STATUS, q);
        chk(q, 64'h3, "status clamped");
        wr(ca(0, SUB_DATA), {16'h0, CODE_ZERO});
        wait_gate(1'b1);
        chk({amp, clamp}, 2'h2, "released");
        wr(ca(1, SUB_DATA), {16'h0, CODE_NEG_FS});
        chk(code[31:0], 64'h8000_0000, "codes");
        rst_in_n <= 1'b0;
        wait_gate(1'b0);
        chk({amp, clamp}, 2'h1, "reset pin");
        rst_in_n <= 1'b1;
        repeat (6) @(posedge mclk);
        #1;
        chk({amp, clamp}, 2'h1, "stays clamped");
        chk(code, 64'h0, "code held at zero");
        wr(ca(2, SUB_DATA), 32'h0000_0001);
        wait_gate(1'b1);
        chk({amp, clamp}, 2'h2, "released again");
        supply_ok <= 1'b0;
        wait_gate(1'b0);
        chk({amp, clamp, mon}, 3'h2, "brownout");
        supply_ok <= 1'b1;
        $display("test clamp done");
    endtask

    task automatic t_io();
        logic [31:0] q;
        ext0 <= 1'b0;
        ext1 <= 1'b1;
        wr(ADDR_IO, 32'h0000_0003);
        repeat (3) @(posedge mclk);
        rd(ADDR_IO, q);
        chk(q, 64'h2, "input pins");
        chk({oe0, oe1, out0, out1}, 4'h0, "inputs idle");
        wr(ADDR_FUNC, 32'h0000_0002);
        chk({oe0, oe1, out0, out1, lgnd}, 5'h18, "outputs");
        wr(ADDR_IO, 32'h0000_0001);
        chk({out0, out1}, 2'h2, "drive one");
        repeat (3) @(posedge mclk);
        rd(ADDR_IO, q);
        chk(q, 64'h1, "driven pins");
        wr(ADDR_FUNC, 32'h0000_0001);
        chk({oe0, oe1, lgnd}, 3'h1, "lgnd on");
        $display("test io done");
    endtask

    // Enable low freezes the synchronisers and the monitor pin
    task automatic t_freeze();
        @(posedge mclk);
        ce        <= 1'b0;
        supply_ok <= 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        chk({mon, clamp}, 2'h3, "frozen by enable");
        @(posedge mclk);
        ce <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        chk({mon, clamp}, 2'h1, "runs again");
        supply_ok <= 1'b1;
        $display("test freeze done");
    endtask

    task automatic t_bad();
        logic [31:0] q;
        logic        e;
        host_u.xfer(1'b0, 8'h0C, 32'h0, q, e);
        chk(e, 64'h1, "unmapped read");
        host_u.xfer(1'b1, 8'hFC, 32'hFFFF_FFFF, q, e);
        chk(e, 64'h1, "unmapped write");
        host_u.xfer(1'b0, ADDR_FUNC, 32'h0, q, e);
        chk({e, q}, 64'h1, "mapped read");
        $display("test unmapped done");
    endtask

    // --------------------------------------------------------------
    // Sequence, watchdog and verdict
    // --------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        #1;
        t_reset();
        t_trims();
        t_clamp();
        t_io();
        t_freeze();
        t_bad();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        $display("BAD %0t watchdog expired", $time);
        conclude();
    end
endmodule
